/* File: dtec_pkg.sv */
// Package with register map, field positions and constants of the dual timer/event counter.
package dtec_pkg;
    // Word indices; byte address is four times the index.
    localparam logic [7:0] IDX_C0_VALUE = 8'h0D;
    localparam logic [7:0] IDX_C0_CTRL = 8'h0E;
    localparam logic [7:0] IDX_C1_HIGH = 8'h0F;
    localparam logic [7:0] IDX_C1_LOW = 8'h10;
    localparam logic [7:0] IDX_C1_CTRL = 8'h11;
    localparam logic [7:0] IDX_IRQ_A = 8'h0B;
    localparam logic [7:0] IDX_IRQ_B = 8'h1E;
    localparam logic [7:0] IDX_PORT_A = 8'h12;
    // Control register fields.
    localparam int EDGE_BIT = 3;
    localparam int RUN_BIT = 4;
    localparam int C1_SRC_BIT = 5;
    localparam int MODE_LSB = 6;
    localparam int C0_IRQ_FLAG_BIT = 6;
    localparam int C1_IRQ_FLAG_BIT = 4;
    localparam int C0_IRQ_EN_BIT = 2;
    localparam int C1_IRQ_EN_BIT = 0;
    localparam int PORT_PFD_BIT = 3;
    // Reset values and last divide-by-4 count.
    localparam logic [7:0] C0_CTRL_RST = 8'h08;
    localparam logic [7:0] C1_CTRL_RST = 8'h08;
    localparam logic [6:0] PSC_RST = 7'h00;
    localparam logic [1:0] C1_DIV4_LAST = 2'h3;
    // Modes.
    typedef enum logic [1:0] {
        MODE_UNUSED = 2'h0,
        MODE_EVENT = 2'h1,
        MODE_TIMER = 2'h2,
        MODE_PULSE = 2'h3
    } dtec_mode_e;
    // Pulse-width measurement phase.
    typedef enum logic [1:0] {PW_WAIT, PW_COUNT, PW_DONE} dtec_pw_e;
    // Wishbone request.
    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [7:0] adr;
        logic [7:0] dat;
    } dtec_wb_s;
endpackage

/* File: dtec_props.sv */
// Checker of port relations of the dual timer/event counter.
`timescale 1ns/1ps
module dtec_props
    import dtec_pkg::*;
(
    // Clock and reset.
    input wire logic I_CLK,
    input wire logic I_SRST,
    // Bus and outputs watched.
    input wire logic I_WB_CYC,
    input wire logic I_WB_STB,
    input wire logic I_WB_WE,
    input wire logic [9:0] I_WB_ADR,
    input wire logic [31:0] O_WB_DAT,
    input wire logic O_WB_ACK,
    input wire logic O_WAKE,
    input wire logic O_IRQ_C0,
    input wire logic [6:0] O_PWM_COUNT
);
    // All checks run on the system clock and rest during reset.
    default clocking cb @(posedge I_CLK);
    endclocking
    default disable iff (I_SRST);
    property p_ack_lat;
        I_WB_CYC && I_WB_STB && !O_WB_ACK |=> O_WB_ACK;
    endproperty
    a_ack_lat: assert property (p_ack_lat) else $error("Ack late.");
    property p_ack_one;
        O_WB_ACK |=> !O_WB_ACK;
    endproperty
    a_ack_one: assert property (p_ack_one) else $error("Ack too long.");
    property p_wake_one;
        O_WAKE |=> !O_WAKE;
    endproperty
    a_wake_one: assert property (p_wake_one) else $error("Wake too long.");
    property p_pwm;
        !$past(I_SRST) |-> O_PWM_COUNT == 7'($past(O_PWM_COUNT) + 7'h01);
    endproperty
    a_pwm: assert property (p_pwm) else $error("Prescaler skipped.");
    property p_rst;
        $past(I_SRST) |-> !O_WB_ACK && !O_WAKE && O_PWM_COUNT == 7'h00;
    endproperty
    a_rst: assert property (p_rst) else $error("Reset state wrong.");
    property p_hi_zero;
        O_WB_ACK |-> O_WB_DAT[31:8] == 24'h000000;
    endproperty
    a_hi_zero: assert property (p_hi_zero) else $error("Upper data set.");
    property p_c0_gap;
        O_WB_ACK && !I_WB_WE && I_WB_ADR[9:2] == IDX_C0_CTRL |-> !O_WB_DAT[5];
    endproperty
    a_c0_gap: assert property (p_c0_gap) else $error("Unused bit set.");
    property p_c1_gap;
        O_WB_ACK && !I_WB_WE && I_WB_ADR[9:2] == IDX_C1_CTRL |-> O_WB_DAT[2:0] == 3'h0;
    endproperty
    a_c1_gap: assert property (p_c1_gap) else $error("Unused bits set.");
    property p_irq_rise;
        $rose(O_IRQ_C0) |-> O_WB_ACK || O_WAKE || $past(O_WAKE);
    endproperty
    a_irq_rise: assert property (p_irq_rise) else $error("Irq without cause.");
    property p_irq_fall;
        $fell(O_IRQ_C0) |-> O_WB_ACK && I_WB_WE;
    endproperty
    a_irq_fall: assert property (p_irq_fall) else $error("Irq dropped alone.");
endmodule
bind dtec_top dtec_props dtec_props_i (.I_CLK(I_CLK), .I_SRST(I_SRST), .I_WB_CYC(I_WB_CYC),
    .I_WB_STB(I_WB_STB), .I_WB_WE(I_WB_WE), .I_WB_ADR(I_WB_ADR), .O_WB_DAT(O_WB_DAT),
    .O_WB_ACK(O_WB_ACK), .O_WAKE(O_WAKE), .O_IRQ_C0(O_IRQ_C0), .O_PWM_COUNT(O_PWM_COUNT));

/* File: dtec_pulse_src.sv */
// Behavioural source of pulses on an external counter pin.
`timescale 1ns/1ps
module dtec_pulse_src (
    // Clock and command.
    input wire logic i_clk,
    input wire logic i_pol,
    input wire logic i_go,
    input wire logic [7:0] i_len,
    // Pin towards the counter.
    output logic o_pin
);
    logic [7:0] cnt = 8'h00;
    // A go request starts one pulse of i_len cycles at the active level.
    always_ff @(posedge i_clk) begin
        if (i_go) begin
            cnt <= i_len;
        end else if (cnt != 8'h00) begin
            cnt <= cnt - 8'h01;
        end
    end
    // The pin rests at the inverse of the active level between pulses.
    assign o_pin = (cnt != 8'h00) ? i_pol : ~i_pol;
endmodule

/* File: dtec_top.sv */
// Dual timer/event counter with Wishbone slave registers.
`timescale 1ns/1ps
// Summary of operation
// - Event and timer modes count up to all-ones, then reload from preload.
// - Overflow sets counter 0 flag bit 6 and counter 1 flag bit 4.
// - Pulse mode starts on chosen edge, stops and clears run on return.
// - Finished pulse result holds until software sets run again.
// - Overflow during pulse mode reloads and raises the flag too.
// - Counter 0 prescale codes divide by 1..64, code 111 by 64.
// - Event mode edge bit: 1 counts falling, 0 counts rising.
// - Pulse mode edge bit 1 measures high, 0 measures low.
// - Bit 4 is the run bit, 0 stops, 1 counts.
// - Counter 1 bit 5 selects clock divided by 4 or 32768Hz.
// - Bits 7:6 pick mode: 01 event, 10 timer, 11 pulse width.
// - Run bit clears automatically only in pulse mode.
// - Any overflow is a wake-up source.
// - Build option picks counter 0 or 1 for the divider output.
// - Cleared interrupt enable blocks servicing of that overflow.
// - Port A line 3 latch enables or forces low the divider output.
// - Write while stopped loads preload and counter both.
// - Write while running loads preload only, counter takes it at overflow.
// - Reading a counter blocks its clock that cycle.
// - The counter 0 prescaler also feeds the PWM clock.
// - Divider output toggles on each overflow of its counter.
// - Counter 1 low byte write buffers, high byte write transfers both.
module dtec_top
    import dtec_pkg::*;
#(
    parameter bit PFD_FROM_C1 = 1'b0
) (
    // Clock and reset.
    input wire logic I_CLK,
    input wire logic I_SRST,
    // Wishbone slave.
    input wire logic I_WB_CYC,
    input wire logic I_WB_STB,
    input wire logic I_WB_WE,
    input wire logic [9:0] I_WB_ADR,
    input wire logic [3:0] I_WB_SEL,
    input wire logic [31:0] I_WB_DAT,
    output logic [31:0] O_WB_DAT,
    output logic O_WB_ACK,
    // External pins and low-speed clock.
    input wire logic I_C0_PIN,
    input wire logic I_C1_PIN,
    input wire logic I_CLK_32K,
    // Outputs to the system.
    output logic O_FREQ_DIV,
    output logic O_WAKE,
    output logic O_IRQ_C0,
    output logic O_IRQ_C1,
    output logic [6:0] O_PWM_COUNT
);
    dtec_wb_s req;
    logic [1:0] s0, s1, s32;
    logic p0, p1, k32;
    logic [7:0] c0_ctrl, c1_ctrl, irq_a, irq_b, port_a;
    logic [7:0] c0_cnt, c0_pre, c1_lowbuf;
    logic [15:0] c1_cnt, c1_pre;
    logic [6:0] psc;
    logic [1:0] div4;
    logic c0_tick_int, c1_tick_int, c0_ext_prev, c1_ext_prev, k32_prev;
    logic c0_ovf, c1_ovf, c0_inc, c1_inc, freq_divider_out;
    logic wr, rd, ack;
    logic wr_c0v, wr_c0c, wr_c1h, wr_c1l, wr_c1c;
    logic rd_c0v, rd_c1h;
    logic c0_done_clr, c1_done_clr;
    dtec_pw_e c0_pw, c1_pw;
    logic [7:0] next_rdata;

    // Bus request bundle; only byte lane 0 carries data.
    // A request is taken at each edge where ack is low, so a request held past
    // its ack is taken again two cycles later and writes or repeats a read side effect.
    assign req = '{cyc: I_WB_CYC, stb: I_WB_STB, we: I_WB_WE, adr: I_WB_ADR[9:2], dat: I_WB_DAT[7:0]};
    assign wr = req.cyc && req.stb && req.we && !ack && I_WB_SEL[0];
    assign rd = req.cyc && req.stb && !req.we && !ack;
    assign wr_c0v = wr && (req.adr == IDX_C0_VALUE);
    assign wr_c0c = wr && (req.adr == IDX_C0_CTRL);
    assign wr_c1h = wr && (req.adr == IDX_C1_HIGH);
    assign wr_c1l = wr && (req.adr == IDX_C1_LOW);
    assign wr_c1c = wr && (req.adr == IDX_C1_CTRL);
    assign rd_c0v = rd && (req.adr == IDX_C0_VALUE);
    assign rd_c1h = rd && (req.adr == IDX_C1_HIGH);
    assign O_WB_ACK = ack;

    // Single-wait acknowledge; drops the cycle after it is given.
    // The master must lower its strobe for a cycle before the next request.
    always_ff @(posedge I_CLK) begin
        if (I_SRST) begin
            ack <= 1'b0;
        end else begin
            ack <= req.cyc && req.stb && !ack;
        end
    end

    // Two-stage synchronisers for the pins and the 32768Hz source.
    always_ff @(posedge I_CLK) begin
        if (I_SRST) begin
            s0 <= 2'h0;
            s1 <= 2'h0;
            s32 <= 2'h0;
        end else begin
            s0 <= {s0[0], I_C0_PIN};
            s1 <= {s1[0], I_C1_PIN};
            s32 <= {s32[0], I_CLK_32K};
        end
    end
    assign p0 = s0[1];
    assign p1 = s1[1];
    assign k32 = s32[1];

    // Previous levels for edge detection.
    always_ff @(posedge I_CLK) begin
        if (I_SRST) begin
            c0_ext_prev <= 1'b0;
            c1_ext_prev <= 1'b0;
            k32_prev <= 1'b0;
        end else begin
            c0_ext_prev <= p0;
            c1_ext_prev <= p1;
            k32_prev <= k32;
        end
    end

    // Free-running prescaler shared with the PWM block.
    // It never stops, so the PWM clock keeps running while counters are off.
    always_ff @(posedge I_CLK) begin
        if (I_SRST) begin
            psc <= PSC_RST;
            div4 <= 2'h0;
        end else begin
            psc <= psc + 7'h01;
            div4 <= div4 + 2'h1;
        end
    end
    assign O_PWM_COUNT = psc;

    // Counter 0 internal tick: all lower prescaler bits ones selects divide by 2^n.
    always_comb begin
        case (c0_ctrl[2:0])
            3'h0: c0_tick_int = 1'b1;
            3'h1: c0_tick_int = &psc[0:0];
            3'h2: c0_tick_int = &psc[1:0];
            3'h3: c0_tick_int = &psc[2:0];
            3'h4: c0_tick_int = &psc[3:0];
            3'h5: c0_tick_int = &psc[4:0];
            default: c0_tick_int = &psc[5:0];
        endcase
    end
    // Counter 1 internal tick from divide-by-4 or the slow clock rising edge.
    assign c1_tick_int = c1_ctrl[C1_SRC_BIT] ? (k32 && !k32_prev) : (div4 == C1_DIV4_LAST);

    // Count enable per mode; a read of the value blocks the clock.
    always_comb begin
        c0_inc = 1'b0;
        c1_inc = 1'b0;
        if (c0_ctrl[RUN_BIT] && !rd_c0v) begin
            unique case (dtec_mode_e'(c0_ctrl[7:6]))
                MODE_EVENT: c0_inc = c0_ctrl[EDGE_BIT] ? (c0_ext_prev && !p0) : (!c0_ext_prev && p0);
                MODE_TIMER: c0_inc = c0_tick_int;
                MODE_PULSE: c0_inc = (c0_pw == PW_COUNT) && c0_tick_int;
                MODE_UNUSED: c0_inc = 1'b0;
            endcase
        end
        if (c1_ctrl[RUN_BIT] && !rd_c1h) begin
            unique case (dtec_mode_e'(c1_ctrl[7:6]))
                MODE_EVENT: c1_inc = c1_ctrl[EDGE_BIT] ? (c1_ext_prev && !p1) : (!c1_ext_prev && p1);
                MODE_TIMER: c1_inc = c1_tick_int;
                MODE_PULSE: c1_inc = (c1_pw == PW_COUNT) && c1_tick_int;
                MODE_UNUSED: c1_inc = 1'b0;
            endcase
        end
    end
    assign c0_ovf = c0_inc && (c0_cnt == 8'hFF);
    assign c1_ovf = c1_inc && (c1_cnt == 16'hFFFF);

    // Pulse-width phase for counter 0: edge bit 1 measures high level, 0 low level.
    always_ff @(posedge I_CLK) begin
        if (I_SRST || c0_ctrl[7:6] != MODE_PULSE || !c0_ctrl[RUN_BIT]) begin
            c0_pw <= PW_WAIT;
        end else begin
            unique case (c0_pw)
                PW_WAIT: if (p0 == c0_ctrl[EDGE_BIT] && c0_ext_prev != p0) c0_pw <= PW_COUNT;
                PW_COUNT: if (p0 != c0_ctrl[EDGE_BIT]) c0_pw <= PW_DONE;
                PW_DONE: c0_pw <= PW_DONE;
            endcase
        end
    end
    assign c0_done_clr = (c0_pw == PW_DONE) && c0_ctrl[RUN_BIT];

    // Pulse-width phase for counter 1.
    always_ff @(posedge I_CLK) begin
        if (I_SRST || c1_ctrl[7:6] != MODE_PULSE || !c1_ctrl[RUN_BIT]) begin
            c1_pw <= PW_WAIT;
        end else begin
            unique case (c1_pw)
                PW_WAIT: if (p1 == c1_ctrl[EDGE_BIT] && c1_ext_prev != p1) c1_pw <= PW_COUNT;
                PW_COUNT: if (p1 != c1_ctrl[EDGE_BIT]) c1_pw <= PW_DONE;
                PW_DONE: c1_pw <= PW_DONE;
            endcase
        end
    end
    assign c1_done_clr = (c1_pw == PW_DONE) && c1_ctrl[RUN_BIT];

    // Control registers; automatic run clear only in pulse mode, a software write wins.
    always_ff @(posedge I_CLK) begin
        if (I_SRST) begin
            c0_ctrl <= C0_CTRL_RST;
            c1_ctrl <= C1_CTRL_RST;
        end else begin
            if (wr_c0c) begin
                c0_ctrl <= {req.dat[7:6], 1'b0, req.dat[4:0]};
            end else if (c0_done_clr) begin
                c0_ctrl[RUN_BIT] <= 1'b0;
            end
            if (wr_c1c) begin
                c1_ctrl <= {req.dat[7:3], 3'h0};
            end else if (c1_done_clr) begin
                c1_ctrl[RUN_BIT] <= 1'b0;
            end
        end
    end

    // Counter 0 and its preload.
    always_ff @(posedge I_CLK) begin
        if (I_SRST) begin
            c0_cnt <= 8'h00;
            c0_pre <= 8'h00;
        end else begin
            if (wr_c0v) begin
                c0_pre <= req.dat;
            end
            if (wr_c0v && !c0_ctrl[RUN_BIT]) begin
                c0_cnt <= req.dat;
            end else if (c0_ovf) begin
                c0_cnt <= c0_pre;
            end else if (c0_inc) begin
                c0_cnt <= c0_cnt + 8'h01;
            end
        end
    end

    // Counter 1, its preload and the low-byte buffer.
    always_ff @(posedge I_CLK) begin
        if (I_SRST) begin
            c1_cnt <= 16'h0000;
            c1_pre <= 16'h0000;
            c1_lowbuf <= 8'h00;
        end else begin
            if (wr_c1l) begin
                c1_lowbuf <= req.dat;
            end else if (rd_c1h) begin
                c1_lowbuf <= c1_cnt[7:0];
            end
            if (wr_c1h) begin
                c1_pre <= {req.dat, c1_lowbuf};
            end
            if (wr_c1h && !c1_ctrl[RUN_BIT]) begin
                c1_cnt <= {req.dat, c1_lowbuf};
            end else if (c1_ovf) begin
                c1_cnt <= c1_pre;
            end else if (c1_inc) begin
                c1_cnt <= c1_cnt + 16'h0001;
            end
        end
    end

    // Interrupt control registers; a hardware set beats a software clear.
    always_ff @(posedge I_CLK) begin
        if (I_SRST) begin
            irq_a <= 8'h00;
            irq_b <= 8'h00;
        end else begin
            if (wr && req.adr == IDX_IRQ_A) begin
                irq_a <= {1'b0, req.dat[6:0]};
            end
            if (wr && req.adr == IDX_IRQ_B) begin
                irq_b <= {1'b0, req.dat[6:0]};
            end
            if (c0_ovf) begin
                irq_a[C0_IRQ_FLAG_BIT] <= 1'b1;
            end
            if (c1_ovf) begin
                irq_b[C1_IRQ_FLAG_BIT] <= 1'b1;
            end
        end
    end
    assign O_IRQ_C0 = irq_a[C0_IRQ_FLAG_BIT] && irq_a[C0_IRQ_EN_BIT];
    assign O_IRQ_C1 = irq_b[C1_IRQ_FLAG_BIT] && irq_b[C1_IRQ_EN_BIT];

    // Wake request on any overflow.
    // The pulse lasts one cycle; the halt logic must latch it itself.
    always_ff @(posedge I_CLK) begin
        if (I_SRST) begin
            O_WAKE <= 1'b0;
        end else begin
            O_WAKE <= c0_ovf || c1_ovf;
        end
    end

    // Port A latch and frequency divider toggle.
    always_ff @(posedge I_CLK) begin
        if (I_SRST) begin
            port_a <= 8'hFF;
            freq_divider_out <= 1'b0;
        end else begin
            if (wr && req.adr == IDX_PORT_A) begin
                port_a <= req.dat;
            end
            if (PFD_FROM_C1 ? c1_ovf : c0_ovf) begin
                freq_divider_out <= !freq_divider_out;
            end
        end
    end
    assign O_FREQ_DIV = freq_divider_out && port_a[PORT_PFD_BIT];

    // Read data multiplexer; unmapped words read zero.
    always_comb begin
        case (req.adr)
            IDX_C0_VALUE: next_rdata = c0_cnt;
            IDX_C0_CTRL: next_rdata = c0_ctrl;
            IDX_C1_HIGH: next_rdata = c1_cnt[15:8];
            IDX_C1_LOW: next_rdata = c1_lowbuf;
            IDX_C1_CTRL: next_rdata = c1_ctrl;
            IDX_IRQ_A: next_rdata = irq_a;
            IDX_IRQ_B: next_rdata = irq_b;
            IDX_PORT_A: next_rdata = port_a;
            default: next_rdata = 8'h00;
        endcase
    end

    // Registered read data.
    always_ff @(posedge I_CLK) begin
        if (I_SRST) begin
            O_WB_DAT <= 32'h00000000;
        end else if (rd) begin
            O_WB_DAT <= {24'h000000, next_rdata};
        end
    end
endmodule

/* File: dtec_top_tb.sv */
// Self-checking testbench of the dual timer/event counter.
`timescale 1ns/1ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin err_total++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (b)); end end
module dtec_top_tb
    import dtec_pkg::*;
;
    logic clk = 1'b0, srst = 1'b1, k32 = 1'b0, pol = 1'b1, go = 1'b0, pin;
    logic cyc = 1'b0, stb = 1'b0, we = 1'b0, ack, fdiv, wake, irq0, irq1, f1;
    logic [9:0] adr = 10'h000;
    logic [31:0] wdat = 32'h0, rdat;
    logic [7:0] len = 8'h14, d, v;
    logic [6:0] pwm;
    int err_total = 0, total_checks = 0, cycles = 0, n;
    dtec_top dtec_top_i (.I_CLK(clk), .I_SRST(srst), .I_WB_CYC(cyc), .I_WB_STB(stb), .I_WB_WE(we),
        .I_WB_ADR(adr), .I_WB_SEL(4'hF), .I_WB_DAT(wdat), .O_WB_DAT(rdat), .O_WB_ACK(ack),
        .I_C0_PIN(pin), .I_C1_PIN(pin), .I_CLK_32K(k32), .O_FREQ_DIV(fdiv), .O_WAKE(wake),
        .O_IRQ_C0(irq0), .O_IRQ_C1(irq1), .O_PWM_COUNT(pwm));
    dtec_pulse_src dtec_pulse_src_i (.i_clk(clk), .i_pol(pol), .i_go(go), .i_len(len), .o_pin(pin));
    // System clock of 100 ns and a free 32768Hz source.
    initial forever #50 clk = ~clk;
    initial forever #15259 k32 = ~k32;
    // One bus cycle held until ack is sampled high.
    task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] x);
        @(posedge clk);
        cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= {a, 2'b00}; wdat <= {24'h0, x};
        do @(posedge clk); while (ack !== 1'b1);
        d = rdat[7:0];
        cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
    endtask
    // Counts cycles up to the next wake pulse.
    task automatic wait_wake();
        n = 0;
        do begin @(posedge clk); n++; end while (wake !== 1'b1 && n < 5000);
    endtask
    // Sends one pin pulse and lets it settle.
    task automatic pulse(input int gap);
        @(posedge clk); go <= 1'b1;
        @(posedge clk); go <= 1'b0;
        repeat (gap) @(posedge clk);
    endtask
    // Prints the counts and the verdict, then ends the run.
    task automatic final_report();
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    // Cuts a hung run short.
    always @(posedge clk) begin
        cycles++;
        if (cycles == 40000) begin err_total++; final_report(); end
    end
    // Main sequence.
    initial begin
        repeat (5) @(posedge clk);
        srst <= 1'b0;
        bus(0, IDX_C0_CTRL, 0); `CHK(d, C0_CTRL_RST)
        bus(0, IDX_C1_CTRL, 0); `CHK(d, C1_CTRL_RST)
        bus(1, IDX_C0_CTRL, 8'h27); bus(0, IDX_C0_CTRL, 0); `CHK(d, 8'h07)
        bus(1, IDX_C1_CTRL, 8'h27); bus(0, IDX_C1_CTRL, 0); `CHK(d, 8'h20)
        bus(0, 8'h30, 0); `CHK(d, 8'h00)
        for (int c = 0; c < 8; c++) begin
            bus(1, IDX_C0_CTRL, 8'h80); bus(1, IDX_C0_VALUE, 8'hFE);
            bus(0, IDX_C0_VALUE, 0); `CHK(d, 8'hFE)
            bus(1, IDX_C0_CTRL, 8'h90 | 8'(c)); wait_wake(); f1 = fdiv; wait_wake();
            `CHK(n, 2 << (c > 6 ? 6 : c))
            `CHK(fdiv, ~f1)
        end
        bus(0, IDX_C0_CTRL, 0); `CHK(d, 8'h97)
        bus(1, IDX_C0_VALUE, 8'hFC); wait_wake(); wait_wake(); `CHK(n, 256)
        bus(1, IDX_PORT_A, 8'h00); `CHK(fdiv, 1'b0)
        bus(0, IDX_IRQ_A, 0); `CHK(d[C0_IRQ_FLAG_BIT], 1'b1)
        `CHK(irq0, 1'b0)
        bus(1, IDX_IRQ_A, 8'h44); `CHK(irq0, 1'b1)
        bus(1, IDX_C0_CTRL, 8'h80); bus(1, IDX_IRQ_A, 8'h04); `CHK(irq0, 1'b0)
        bus(1, IDX_C1_LOW, 8'hFE); bus(1, IDX_C1_HIGH, 8'hFF);
        bus(0, IDX_C1_HIGH, 0); `CHK(d, 8'hFF)
        bus(0, IDX_C1_LOW, 0); `CHK(d, 8'hFE)
        bus(1, IDX_C1_CTRL, 8'h90); wait_wake(); wait_wake(); `CHK(n, 8)
        bus(1, IDX_C1_CTRL, 8'h80); bus(1, IDX_C1_LOW, 8'hFE); bus(1, IDX_C1_HIGH, 8'hFF);
        bus(1, IDX_C1_CTRL, 8'hB0); wait_wake(); wait_wake();
        `CHK(n >= 608 && n <= 613, 1'b1)
        bus(1, IDX_C1_CTRL, 8'h80); bus(1, IDX_IRQ_B, 8'h11); `CHK(irq1, 1'b1)
        for (int e = 0; e < 2; e++) begin
            bus(1, IDX_C0_CTRL, 8'h40 | 8'(e << 3)); bus(1, IDX_C0_VALUE, 8'hF0);
            bus(1, IDX_C0_CTRL, 8'h50 | 8'(e << 3)); pulse(8);
            bus(0, IDX_C0_VALUE, 0); `CHK(d, 8'hF1 - 8'(e))
            repeat (20) @(posedge clk);
            bus(0, IDX_C0_VALUE, 0); `CHK(d, 8'hF1)
        end
        for (int e = 0; e < 2; e++) begin
            pol <= 1'(e);
            bus(1, IDX_C0_CTRL, 8'hC0 | 8'(e << 3)); bus(1, IDX_C0_VALUE, 8'h00);
            bus(1, IDX_C0_CTRL, 8'hD0 | 8'(e << 3)); pulse(40);
            bus(0, IDX_C0_CTRL, 0); `CHK(d, 8'hC0 | 8'(e << 3))
            bus(0, IDX_C0_VALUE, 0); v = d; `CHK(v >= 8'h13 && v <= 8'h15, 1'b1)
            pulse(40); bus(0, IDX_C0_VALUE, 0); `CHK(d, v)
        end
        final_report();
    end
endmodule
